// ---- timer_module.sv ----
// 16-bit capture/compare/pwm timer with wishbone registers
// ---------------------------------------------------------------
// How it works
// - one shared two-way pin per channel, 1-8
// - 16-bit counter, free or modulo, up/down centred
// - modulo all zeros or all ones runs free
// - counter reads never disturb counting
// - any counter byte write clears it
// - centre select makes every channel centre pwm
// - shared external clock pin drops channel pin
// - pin released when edge select or clock off
// - centre select or mode bits choose channel function
// - capture mode pin is edge input
// - capture input synchronised; four cycles reliable
// - compare toggles, clears or sets on match
// - toggle keeps old level until match
// - high-true pwm: high at zero, low at match
// - low-true pwm: low at zero, high at match
// - centre high-true: clear up, set down
// - centre low-true: set up, clear down
// - centre mode up to modulo, down to zero
// - edge pwm period is modulo plus one
// - clock select off, bus, fixed, external
// ---------------------------------------------------------------
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_module
   import timer_pkg::*;
#(
   parameter int N_CH = CH_MAX,
   parameter bit EXT_SHARED = 1'b1,
   parameter int EXT_CH = 0
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // count sources
   input wire logic fixed_tick_i,
   input wire logic external_count_clock_i,
   // channel pins
   input wire logic [N_CH-1:0] channel_pin_i,
   output logic [N_CH-1:0] channel_pin_o,
   output logic [N_CH-1:0] channel_pin_oe_n_o
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [N_CH:0] pin_lvl;

   in_sync #(
      .W(N_CH + 1)
   )
   u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({external_count_clock_i, channel_pin_i}),
      .q_o(pin_lvl)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic req, wr, rd_req, al;
   logic a_ctrl, a_count, a_mod, a_stat, a_cctl, a_cval;
   logic [2:0] idx;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt, rd;

   assign req = wb_cyc_i && wb_stb_i;
   assign wr = req && wb_we_i && ack_r;
   assign rd_req = req && !wb_we_i && !ack_r;
   assign idx = wb_adr_i[4:2];
   assign al = (wb_adr_i[1:0] == 2'h0);
   assign a_ctrl = (wb_adr_i == OFS_CTRL);
   assign a_count = (wb_adr_i == OFS_COUNT);
   assign a_mod = (wb_adr_i == OFS_MOD);
   assign a_stat = (wb_adr_i == OFS_STAT);
   assign a_cctl = al && (wb_adr_i[7:5] == CCTL_PAGE) && (int'(idx) < N_CH);
   assign a_cval = al && (wb_adr_i[7:5] == CVAL_PAGE) && (int'(idx) < N_CH);

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [1:0] clks_r, clks_nxt;
   logic ca_r, ca_nxt;
   logic [2:0] ps_r, ps_nxt;
   logic [15:0] mod_r, mod_nxt;
   chan_cfg_s cfg_r [N_CH];
   chan_cfg_s cfg_nxt [N_CH];

   always_comb
   begin
      clks_nxt = clks_r;
      ca_nxt = ca_r;
      ps_nxt = ps_r;
      mod_nxt = mod_r;
      cfg_nxt = cfg_r;
      if (wr && a_ctrl && wb_sel_i[0])
      begin
         clks_nxt = wb_dat_i[CTRL_CLKS_LSB +: 2];
         ca_nxt = wb_dat_i[CTRL_CA_BIT];
         ps_nxt = wb_dat_i[CTRL_PS_LSB +: 3];
      end
      if (wr && a_mod)
      begin
         if (wb_sel_i[0])
            mod_nxt[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1])
            mod_nxt[15:8] = wb_dat_i[15:8];
      end
      for (int n = 0; n < N_CH; n++)
      begin
         if (wr && a_cctl && int'(idx) == n && wb_sel_i[0])
            cfg_nxt[n] = chan_cfg_s'(wb_dat_i[3:0]);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clks_r <= CLKS_OFF;
         ca_r <= 1'b0;
         ps_r <= 3'h0;
         mod_r <= MOD_RST;
         for (int n = 0; n < N_CH; n++)
            cfg_r[n] <= '0;
      end
      else
      begin
         clks_r <= clks_nxt;
         ca_r <= ca_nxt;
         ps_r <= ps_nxt;
         mod_r <= mod_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // ---------------------------------------------------------------
   // clock source, prescaler and counter
   // ---------------------------------------------------------------
   logic ext_lvl, ext_rise, src_tick, pre_tick, cnt_clr, ovf_set;
   logic [6:0] pre_r, pre_nxt, pre_mask;
   logic [15:0] cnt_r, cnt_nxt, eff_mod;
   logic up_r, up_nxt, step_r, step_nxt, ext_prev_r;
   cnt_bus_s cbus;

   assign ext_lvl = EXT_SHARED ? pin_lvl[EXT_CH] : pin_lvl[N_CH];
   assign ext_rise = ext_lvl && !ext_prev_r;
   assign pre_mask = 7'h7F >> (3'h7 - ps_r);
   assign pre_tick = src_tick && ((pre_r & pre_mask) == pre_mask);
   assign cnt_clr = wr && a_count && (|wb_sel_i[1:0]);
   assign eff_mod = (mod_r == MOD_FREE_LO || mod_r == MOD_FREE_HI) ? MOD_FREE_HI : mod_r;

   always_comb
   begin
      unique case (clks_r)
         CLKS_OFF: src_tick = 1'b0;
         CLKS_BUS: src_tick = 1'b1;
         CLKS_FIX: src_tick = fixed_tick_i;
         CLKS_EXT: src_tick = ext_rise;
      endcase
   end

   always_comb
   begin
      cnt_nxt = cnt_r;
      up_nxt = up_r;
      pre_nxt = pre_r;
      step_nxt = 1'b0;
      ovf_set = 1'b0;
      if (src_tick)
         pre_nxt = pre_r + 7'h01;
      if (cnt_clr)
      begin
         cnt_nxt = CNT_RST;
         up_nxt = 1'b1;
         pre_nxt = PRE_RST;
      end
      else if (pre_tick)
      begin
         step_nxt = 1'b1;
         if (!ca_r)
         begin
            up_nxt = 1'b1;
            if (cnt_r == eff_mod)
            begin
               cnt_nxt = CNT_RST;
               ovf_set = 1'b1;
            end
            else
               cnt_nxt = cnt_r + 16'h0001;
         end
         else if (up_r)
         begin
            if (cnt_r >= eff_mod)
            begin
               up_nxt = 1'b0;
               cnt_nxt = cnt_r - 16'h0001;
            end
            else
               cnt_nxt = cnt_r + 16'h0001;
         end
         else if (cnt_r == CNT_RST)
         begin
            up_nxt = 1'b1;
            cnt_nxt = 16'h0001;
         end
         else
         begin
            cnt_nxt = cnt_r - 16'h0001;
            ovf_set = (cnt_r == 16'h0001);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_r <= CNT_RST;
         up_r <= 1'b1;
         pre_r <= PRE_RST;
         step_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         up_r <= up_nxt;
         pre_r <= pre_nxt;
         step_r <= step_nxt;
         ext_prev_r <= ext_lvl;
      end
   end

   assign cbus = '{value: cnt_r, step: step_r, up: up_r};

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   logic [N_CH-1:0] ch_flag;
   logic [15:0] cv_w [N_CH];

   for (genvar g = 0; g < N_CH; g++)
   begin : g_ch
      chan_unit u_ch (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .cnt_i(cbus),
         .cfg_i(cfg_r[g]),
         .ca_i(ca_r),
         .clk_on_i(clks_r != CLKS_OFF),
         .pin_lost_i(EXT_SHARED && g == EXT_CH && clks_r == CLKS_EXT),
         .pin_lvl_i(pin_lvl[g]),
         .pin_o(channel_pin_o[g]),
         .pin_oe_n_o(channel_pin_oe_n_o[g]),
         .cv_wr_i(wr && a_cval && int'(idx) == g),
         .cv_sel_i(wb_sel_i[1:0]),
         .cv_wdata_i(wb_dat_i[15:0]),
         .cv_o(cv_w[g]),
         .flag_o(ch_flag[g])
      );
   end

   // ---------------------------------------------------------------
   // status flags, write one to clear, set wins
   // ---------------------------------------------------------------
   logic ovf_r, ovf_nxt;
   logic [N_CH-1:0] chf_r, chf_nxt, chf_clr;

   always_comb
   begin
      chf_clr = '0;
      if (wr && a_stat && wb_sel_i[1])
         chf_clr = wb_dat_i[STAT_CH_LSB +: N_CH];
      ovf_nxt = ovf_set || (ovf_r && !(wr && a_stat && wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT]));
      chf_nxt = ch_flag | (chf_r & ~chf_clr);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ovf_r <= 1'b0;
         chf_r <= '0;
      end
      else
      begin
         ovf_r <= ovf_nxt;
         chf_r <= chf_nxt;
      end
   end

   // ---------------------------------------------------------------
   // read mux and acknowledge
   // ---------------------------------------------------------------
   always_comb
   begin
      rd = 32'h0000_0000;
      if (a_ctrl)
      begin
         rd[CTRL_CLKS_LSB +: 2] = clks_r;
         rd[CTRL_CA_BIT] = ca_r;
         rd[CTRL_PS_LSB +: 3] = ps_r;
      end
      if (a_count)
         rd[15:0] = cnt_r;
      if (a_mod)
         rd[15:0] = mod_r;
      if (a_stat)
      begin
         rd[STAT_OVF_BIT] = ovf_r;
         rd[STAT_CH_LSB +: N_CH] = chf_r;
      end
      for (int n = 0; n < N_CH; n++)
      begin
         if (a_cctl && int'(idx) == n)
            rd[3:0] = cfg_r[n];
         if (a_cval && int'(idx) == n)
            rd[15:0] = cv_w[n];
      end
   end

   always_comb
   begin
      ack_nxt = req && !ack_r;
      dat_nxt = rd_req ? rd : dat_r;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_free;
      !ca_r && mod_r == MOD_FREE_LO && pre_tick && !cnt_clr && cnt_r == MOD_FREE_HI
         |=> cnt_r == CNT_RST;
   endproperty
   a_free: assert property (p_free) else $error("free run did not wrap at top");
   property p_clr;
      cnt_clr |=> cnt_r == CNT_RST;
   endproperty
   a_clr: assert property (p_clr) else $error("counter write did not clear");
   property p_read;
      rd_req && a_count && !pre_tick |=> cnt_r == $past(cnt_r) ##1 wb_dat_o[15:0] == $past(cnt_r, 2);
   endproperty
   a_read: assert property (p_read) else $error("counter read disturbed count");
   property p_off;
      clks_r == CLKS_OFF && !cnt_clr |=> cnt_r == $past(cnt_r);
   endproperty
   a_off: assert property (p_off) else $error("counter moved with no clock");
   property p_turn;
      ca_r && up_r && pre_tick && !cnt_clr && cnt_r == eff_mod |=> !up_r && cnt_r == $past(eff_mod) - 16'h0001;
   endproperty
   a_turn: assert property (p_turn) else $error("centre count did not turn");
   property p_wrap;
      !ca_r && pre_tick && !cnt_clr && cnt_r == eff_mod |=> cnt_r == CNT_RST && ovf_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("edge period end missed");
   property p_rel;
      clks_r == CLKS_OFF |-> &channel_pin_oe_n_o;
   endproperty
   a_rel: assert property (p_rel) else $error("pin driven with clock off");
   property p_bus;
      clks_r == CLKS_BUS && ps_r == 3'h0 && !ca_r && !cnt_clr && cnt_r != eff_mod
         |=> cnt_r == $past(cnt_r) + 16'h0001;
   endproperty
   a_bus: assert property (p_bus) else $error("bus clock count missed");
   c_ovf: cover property (ovf_set);
   c_turn: cover property (ca_r && up_r && pre_tick && cnt_r == eff_mod);
   c_ext: cover property (clks_r == CLKS_EXT && pre_tick);
endmodule
`default_nettype wire

// ---- tpm_pkg.sv ----
// constants and carrier types of the capture/compare/pwm timer
package timer_pkg;
   localparam int CH_MAX = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_MOD = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   // per-channel pages, channel n at page base + 4n
   localparam logic [2:0] CCTL_PAGE = 3'h1;
   localparam logic [2:0] CVAL_PAGE = 3'h2;
   // field positions
   localparam int CTRL_CLKS_LSB = 0;
   localparam int CTRL_CA_BIT = 2;
   localparam int CTRL_PS_LSB = 3;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_CH_LSB = 8;
   // reset values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] MOD_RST = 16'h0000;
   localparam logic [15:0] CV_RST = 16'h0000;
   localparam logic [6:0] PRE_RST = 7'h00;
   // counter limits
   localparam logic [15:0] MOD_FREE_LO = 16'h0000;
   localparam logic [15:0] MOD_FREE_HI = 16'hFFFF;
   // clock select codes
   localparam logic [1:0] CLKS_OFF = 2'h0;
   localparam logic [1:0] CLKS_BUS = 2'h1;
   localparam logic [1:0] CLKS_FIX = 2'h2;
   localparam logic [1:0] CLKS_EXT = 2'h3;
   // channel mode and edge/level codes
   localparam logic [1:0] MS_CAPT = 2'h0;
   localparam logic [1:0] MS_COMP = 2'h1;
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_TGL = 2'h1;
   localparam logic [1:0] ELS_HI_TRUE = 2'h2;
   typedef struct packed {
      logic [1:0] ms;
      logic [1:0] els;
   } chan_cfg_s;
   typedef struct packed {
      logic [15:0] value;
      logic step;
      logic up;
   } cnt_bus_s;
endpackage

// ---- in_sync.sv ----
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module in_sync #(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous levels in, stable levels out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r;
   logic [W-1:0] q_nxt;

   always_comb
   begin
      q_nxt = q_r;
      for (int i = 0; i < W; i++)
      begin
         if (s2_r[i] == s3_r[i])
         begin
            q_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end
      else
      begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_agree;
      (q_r != $past(q_r)) |-> ((q_r ^ $past(q_r)) & ($past(s2_r) ^ $past(s3_r))) == '0;
   endproperty
   a_agree: assert property (p_agree) else $error("level taken before stages agreed");
endmodule
`default_nettype wire

// ---- chan_unit.sv ----
// one timer channel: capture, compare, edge and center pwm
`timescale 1ns/1ps
`default_nettype none
module chan_unit
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // counter and module settings
   input wire cnt_bus_s cnt_i,
   input wire chan_cfg_s cfg_i,
   input wire logic ca_i,
   input wire logic clk_on_i,
   input wire logic pin_lost_i,
   // pin
   input wire logic pin_lvl_i,
   output logic pin_o,
   output logic pin_oe_n_o,
   // channel value access
   input wire logic cv_wr_i,
   input wire logic [1:0] cv_sel_i,
   input wire logic [15:0] cv_wdata_i,
   output logic [15:0] cv_o,
   output logic flag_o
);
   logic active, capt, comp, edge_aligned_pwm, match, rise, fall, cap_hit;
   logic [15:0] cv_r, cv_nxt;
   logic lvl_r, lvl_nxt, prev_r;

   assign active = (cfg_i.els != ELS_OFF) && clk_on_i && !pin_lost_i;
   assign capt = !ca_i && (cfg_i.ms == MS_CAPT);
   assign comp = !ca_i && (cfg_i.ms == MS_COMP);
   assign edge_aligned_pwm = !ca_i && cfg_i.ms[1];
   assign match = cnt_i.step && (cnt_i.value == cv_r);
   assign rise = pin_lvl_i && !prev_r;
   assign fall = !pin_lvl_i && prev_r;
   assign cap_hit = capt && active && ((cfg_i.els[0] && rise) || (cfg_i.els[1] && fall));

   always_comb
   begin
      cv_nxt = cv_r;
      lvl_nxt = lvl_r;
      flag_o = 1'b0;
      if (cv_wr_i)
      begin
         if (cv_sel_i[0])
            cv_nxt[7:0] = cv_wdata_i[7:0];
         if (cv_sel_i[1])
            cv_nxt[15:8] = cv_wdata_i[15:8];
      end
      if (cap_hit)
      begin
         cv_nxt = cnt_i.value;
         flag_o = 1'b1;
      end
      if (comp && match)
      begin
         flag_o = 1'b1;
         if (active)
            lvl_nxt = (cfg_i.els == ELS_TGL) ? !lvl_r : cfg_i.els[0];
      end
      if (edge_aligned_pwm)
      begin
         if (active && cnt_i.step && cnt_i.value == CNT_RST)
            lvl_nxt = !cfg_i.els[0];
         if (match)
         begin
            flag_o = 1'b1;
            if (active)
               lvl_nxt = cfg_i.els[0];
         end
      end
      if (ca_i && match)
      begin
         flag_o = 1'b1;
         if (active)
            lvl_nxt = cnt_i.up ? cfg_i.els[0] : !cfg_i.els[0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cv_r <= CV_RST;
         lvl_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         cv_r <= cv_nxt;
         lvl_r <= lvl_nxt;
         prev_r <= pin_lvl_i;
      end
   end

   assign pin_o = lvl_r;
   assign pin_oe_n_o = !(active && !capt);
   assign cv_o = cv_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_oc_set;
      comp && active && cfg_i.els == 2'h3 && match |=> pin_o;
   endproperty
   a_oc_set: assert property (p_oc_set) else $error("compare set missed");
   property p_oc_hold;
      comp && active && cfg_i.els == ELS_TGL && !match |=> pin_o == $past(pin_o);
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("toggle moved without match");
   property p_ep_lo;
      edge_aligned_pwm && active && cfg_i.els[0] && cnt_i.step && cnt_i.value == CNT_RST
         && cv_r != CNT_RST |=> !pin_o;
   endproperty
   a_ep_lo: assert property (p_ep_lo) else $error("low-true pwm not low at zero");
   property p_ca_dn;
      ca_i && active && cfg_i.els[0] && match && !cnt_i.up |=> !pin_o;
   endproperty
   a_ca_dn: assert property (p_ca_dn) else $error("center pwm down match wrong");
   property p_cap;
      cap_hit |=> cv_r == $past(cnt_i.value);
   endproperty
   a_cap: assert property (p_cap) else $error("capture did not latch count");
   c_cap: cover property (cap_hit);
endmodule
`default_nettype wire

// ---- pin_partner.sv ----
// pin-side model: external levels on the shared channel wires
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
   parameter int N = 8
)
(
   // timer side
   input wire logic [N-1:0] drv_i,
   input wire logic [N-1:0] oe_n_i,
   // resolved wires
   output logic [N-1:0] wire_o
);
   logic [N-1:0] ext_r = '0;
   // a released pin shows the outside level, else the timer drive
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         wire_o[i] = oe_n_i[i] ? ext_r[i] : drv_i[i];
      end
   end
endmodule
`default_nettype wire

// ---- timer_module_tb.sv ----
// self-checking bench for the timer module
`timescale 1ns/1ps
`default_nettype none
module timer_module_tb;
   import timer_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic fixed_tick_i = 1'b0;
   logic [7:0] pin_w;
   logic [7:0] pin_o;
   logic [7:0] oe_n;
   logic [31:0] q;
   logic [15:0] mods [3] = '{16'h0000, 16'hFFFF, 16'h0008};
   logic [1:0] cap_els [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
   logic cap_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic cap_exp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;

   timer_module dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .fixed_tick_i(fixed_tick_i), .external_count_clock_i(1'b0),
      .channel_pin_i(pin_w), .channel_pin_o(pin_o), .channel_pin_oe_n_o(oe_n));
   pin_partner pp (.drv_i(pin_o), .oe_n_i(oe_n), .wire_o(pin_w));

   always #50 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      fixed_tick_i <= (cycles % 4 == 0);
      if (cycles == 8000)
      begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s = 4'h3);
      @(posedge clk_i);
      wb_sel_i <= s;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i iff wb_ack_o);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   function automatic logic [7:0] cc(input int ch);
      return {CCTL_PAGE, 3'(ch), 2'h0};
   endfunction

   function automatic logic [7:0] cv(input int ch);
      return {CVAL_PAGE, 3'(ch), 2'h0};
   endfunction

   task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_len(input int got, input int exp);
      chk_dat(32'(got), 32'(exp));
   endtask

   // cycles that pin ch spends at level lvl, seen at falling edges
   task automatic span(input int ch, input logic lvl, output int len);
      @(negedge clk_i iff pin_o[ch] !== lvl);
      @(negedge clk_i iff pin_o[ch] === lvl);
      len = 0;
      do
      begin
         len++;
         @(negedge clk_i);
      end
      while (pin_o[ch] === lvl);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk_dat(32'(oe_n), 32'hFF);
      wb(OFS_MOD, 1'b0, 32'h0);
      chk_dat(q, 32'(MOD_RST));
      $display("test reset done");
      wb(OFS_CTRL, 1'b1, 32'(CLKS_BUS));
      repeat (20) @(posedge clk_i);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_OFF));
      wb(OFS_COUNT, 1'b1, 32'hFFFF, 4'h2);
      wb(OFS_COUNT, 1'b0, 32'h0);
      chk_dat(q, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         wb(OFS_MOD, 1'b1, 32'(mods[i]));
         wb(OFS_CTRL, 1'b1, 32'(CLKS_BUS));
         repeat (30) @(posedge clk_i);
         wb(OFS_CTRL, 1'b1, 32'(CLKS_OFF));
         wb(OFS_COUNT, 1'b0, 32'h0);
         chk_dat(32'(q > 32'h10), 32'(i < 2));
         wb(OFS_COUNT, 1'b1, 32'h0);
      end
      wb(OFS_MOD, 1'b1, 32'h0);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_FIX));
      repeat (40) @(posedge clk_i);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_OFF));
      wb(OFS_COUNT, 1'b0, 32'h0);
      chk_dat(32'(q > 32'h4 && q < 32'h10), 32'h1);
      wb(OFS_COUNT, 1'b1, 32'h0);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_BUS) | 32'h10);
      repeat (40) @(posedge clk_i);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_OFF));
      wb(OFS_COUNT, 1'b0, 32'h0);
      chk_dat(32'(q > 32'h4 && q < 32'h10), 32'h1);
      wb(OFS_COUNT, 1'b1, 32'h0);
      $display("test counter done");
      wb(OFS_MOD, 1'b1, 32'h8);
      wb(cv(0), 1'b1, 32'h5);
      wb(cc(0), 1'b1, 32'hA);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_BUS));
      span(0, 1'b1, n);
      chk_len(n, 5);
      span(0, 1'b0, n);
      chk_len(n, 4);
      chk_dat(32'(oe_n[0]), 32'h0);
      wb(cc(0), 1'b1, 32'h9);
      span(0, 1'b0, n);
      chk_len(n, 5);
      $display("test edge pwm done");
      wb(cv(1), 1'b1, 32'h7);
      wb(OFS_COUNT, 1'b1, 32'h0);
      wb(cc(1), 1'b1, 32'h5);
      @(negedge clk_i);
      chk_dat(32'(pin_o[1]), 32'h0);
      span(1, 1'b1, n);
      chk_len(n, 9);
      for (int i = 0; i < 2; i++)
      begin
         wb(cc(1), 1'b1, 32'(7 - i));
         repeat (12) @(negedge clk_i);
         chk_dat(32'(pin_o[1]), 32'(i == 0));
      end
      wb(cc(1), 1'b1, 32'h4);
      wb(OFS_STAT, 1'b1, 32'h200);
      repeat (12) @(posedge clk_i);
      wb(OFS_STAT, 1'b0, 32'h0);
      chk_dat(32'({q[9], oe_n[1]}), 32'h3);
      wb(cv(1), 1'b0, 32'h0);
      chk_dat(q, 32'h7);
      $display("test compare done");
      for (int i = 0; i < 4; i++)
      begin
         wb(cc(2), 1'b1, 32'(cap_els[i]));
         wb(OFS_STAT, 1'b1, 32'h400);
         pp.ext_r[2] <= cap_lvl[i];
         repeat (8) @(posedge clk_i);
         wb(OFS_STAT, 1'b0, 32'h0);
         chk_dat(32'({q[10], oe_n[2]}), 32'({cap_exp[i], 1'b1}));
      end
      $display("test capture done");
      wb(cc(0), 1'b1, 32'hA);
      wb(cc(1), 1'b1, 32'h7);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_BUS) | 32'h4);
      span(0, 1'b0, n);
      chk_len(n, 6);
      span(0, 1'b1, n);
      chk_len(n, 10);
      span(1, 1'b1, n);
      chk_len(n, 2);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_EXT));
      @(negedge clk_i);
      chk_dat(32'(oe_n[0]), 32'h1);
      wb(cc(0), 1'b1, 32'h4);
      wb(cv(0), 1'b1, 32'h2);
      wb(OFS_COUNT, 1'b1, 32'h0);
      wb(OFS_STAT, 1'b1, 32'h100);
      repeat (6)
      begin
         repeat (4) @(posedge clk_i);
         pp.ext_r[0] <= ~pp.ext_r[0];
      end
      repeat (8) @(posedge clk_i);
      wb(OFS_COUNT, 1'b0, 32'h0);
      chk_dat(q, 32'h3);
      wb(OFS_STAT, 1'b0, 32'h0);
      chk_dat(32'({q[8], oe_n[0]}), 32'h3);
      wb(OFS_CTRL, 1'b1, 32'(CLKS_OFF));
      @(negedge clk_i);
      chk_dat(32'(oe_n), 32'hFF);
      $display("test center pwm done");
      wrap_up();
   end
endmodule
`default_nettype wire
